// ### include/sif_cfg_defs.vh
`ifndef SIF_CFG_DEFS_VH
`define SIF_CFG_DEFS_VH
// register indices (word addresses on the host port)
`define SIF_MCR1_ADDR 16'h0000
`define SIF_MCR2_ADDR 16'h004E
`define SIF_SWB_ADDR 16'h001A
// field positions
`define SIF_MCR1_START_BIT 4
`define SIF_MCR2_MODE_BIT 7
`define SIF_MCR2_FTEST_BIT 4
`define SIF_MCR2_WATCHDOG_TIMEOUT_FLAG_ENABLE_BIT 3
`define SIF_SWB_FLAG_BIT 0
// reset values
`define SIF_MCR2_RESET 8'h00
`define SIF_SWB_RESET 16'h0000
// watchdog limit in ns and cycles at 4 ns
`define SIF_WDOG_NS 663000
`define SIF_CLK_NS 4
`define SIF_WDOG_CYC (`SIF_WDOG_NS / `SIF_CLK_NS)
`endif

// ### logic/sif_tx_watchdog.v
`timescale 1ns/1ns
`default_nettype none
`include "sif_cfg_defs.vh"
module sif_tx_watchdog #(
  parameter integer LIMIT = `SIF_WDOG_CYC
)
(
  // clock and reset
  input wire clk,
  input wire rst_n,
  // transmitter activity
  input wire txActive,
  // timeout outputs
  output reg txStop,
  output reg timeoutPulse
);
  reg [17:0] count;
  reg expired;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      count <= 18'h00000;
      expired <= 1'b0;
      txStop <= 1'b0;
      timeoutPulse <= 1'b0;
    end
    else
    begin
      timeoutPulse <= 1'b0;
      if (!txActive)
      begin
        count <= 18'h00000;
        expired <= 1'b0;
        txStop <= 1'b0;
      end
      else if (!expired)
      begin
        if (count == LIMIT[17:0] - 18'h00001)
        begin
          expired <= 1'b1;
          txStop <= 1'b1;
          timeoutPulse <= 1'b1;
        end
        else
        begin
          count <= count + 18'h00001;
        end
      end
    end
  end
endmodule // sif_tx_watchdog
`default_nettype wire

// ### logic/sif_cfg_bank.v
`timescale 1ns/1ns
`default_nettype none
`include "sif_cfg_defs.vh"
// Notes on behaviour
// - mode bit 7 set when mode pin is high at master reset rising edge
// - in store mode, answer own-address valid commands at once with Busy
// - in store mode, no data words, no interrupts, no logging
// - forced Busy stays available during self-test and initialization
// - host writing one to mode bit leaves store mode, clears bit
// - writing one to start-execution bit 4 of register 0 leaves store mode
// - mode pin going low leaves store mode, clears bit
// - bits 6 and 5 read zero and reset to zero
// - flag test bit forces Terminal Flag on valid non-broadcast replies
// - watchdog flag enable lets timeout set status flag bit 0
// - transmitter watchdog stops transmissions longer than 663 us
module sif_cfg_bank #(
  parameter integer WDOG_CYCLES = `SIF_WDOG_CYC
)
(
  // clock and reset
  input wire clk,
  input wire rst_n,
  // device pins
  input wire masterResetPin,
  input wire storeInterfaceModePin,
  // host register port (word address, one-cycle strobes)
  input wire [15:0] hostAddr,
  input wire hostWrite,
  input wire hostRead,
  input wire [15:0] hostWdata,
  output reg [15:0] hostRdata,
  output reg hostRvalid,
  // protocol engine side
  input wire cmdValid,
  input wire cmdOwnAddr,
  input wire cmdBroadcast,
  input wire txActive,
  output reg forceBusy,
  output reg forceFlag,
  output reg suppressData,
  output reg suppressIrq,
  output reg suppressLog,
  output reg txStop,
  output reg storeModeActive,
  output reg terminalFlagBit
);
  // pin synchronisers; bit 0 is the master reset pin, bit 1 the mode pin
  localparam [1:0] PIN_IDLE = 2'h1;
  wire [1:0] pinRaw;
  wire [1:0] pinSync;
  wire mrSync;
  wire modeSync;
  reg mrPrev;
  // register state
  reg storeMode;
  reg flagTestEnable;
  reg watchdogTimeoutFlagEnable;
  reg [15:0] statusWordBits;
  wire wdStop;
  wire wdTimeout;
  wire mrRise;
  wire wrMcr2;
  wire wrMcr1;
  wire wrSwb;
  wire exitMode;
  wire [7:0] mcr2Value;
  wire exitByWrite;
  wire exitByStart;
  wire exitByPin;
  reg next_storeMode;
  reg [15:0] next_statusWordBits;
  reg [15:0] next_hostRdata;
  reg next_forceBusy;
  reg next_forceFlag;

  // flops leave reset at each pin's idle level, so a master reset pin that
  // is already high when rst_n lifts is not taken for a rising edge
  assign pinRaw = {storeInterfaceModePin, masterResetPin};

  genvar pinIdx;
  generate
    for (pinIdx = 0; pinIdx < 2; pinIdx = pinIdx + 1)
    begin : gPinSync
      reg meta;
      reg sync;
      always @(posedge clk)
      begin
        if (!rst_n)
        begin
          meta <= PIN_IDLE[pinIdx];
          sync <= PIN_IDLE[pinIdx];
        end
        else
        begin
          meta <= pinRaw[pinIdx];
          sync <= meta;
        end
      end
      assign pinSync[pinIdx] = sync;
    end
  endgenerate

  assign mrSync = pinSync[0];
  assign modeSync = pinSync[1];

  // edge detector on the synchronised pin, idle high like the pin itself
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      mrPrev <= 1'b1;
    end
    else
    begin
      mrPrev <= mrSync;
    end
  end

  assign mrRise = mrSync & ~mrPrev;
  assign wrMcr2 = hostWrite && (hostAddr == `SIF_MCR2_ADDR);
  assign wrMcr1 = hostWrite && (hostAddr == `SIF_MCR1_ADDR);
  assign wrSwb = hostWrite && (hostAddr == `SIF_SWB_ADDR);
  // any one of three exits; pin low also blocks entry
  assign exitByWrite = wrMcr2 && hostWdata[`SIF_MCR2_MODE_BIT];
  assign exitByStart = wrMcr1 && hostWdata[`SIF_MCR1_START_BIT];
  assign exitByPin = !modeSync;
  assign exitMode = exitByWrite || exitByStart || exitByPin;

  // entry is tested first: a master reset edge with the pin high keeps the
  // terminal in mode even if a host exit write lands in the same cycle
  always @*
  begin
    next_storeMode = storeMode;
    if (mrRise && modeSync)
    begin
      next_storeMode = 1'b1;
    end
    else if (exitMode)
    begin
      next_storeMode = 1'b0;
    end
  end

  // the mode bit survives reads and initialization activity untouched, so
  // busy answers go on through self-test and init
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      storeMode <= 1'b0;
    end
    else
    begin
      storeMode <= next_storeMode;
    end
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      flagTestEnable <= 1'b0;
      watchdogTimeoutFlagEnable <= 1'b0;
    end
    else if (wrMcr2)
    begin
      flagTestEnable <= hostWdata[`SIF_MCR2_FTEST_BIT];
      watchdogTimeoutFlagEnable <= hostWdata[`SIF_MCR2_WATCHDOG_TIMEOUT_FLAG_ENABLE_BIT];
    end
  end

  // timeout set wins over a host write in the same cycle, so a flag raised
  // by the watchdog is never lost to a host write that races it
  always @*
  begin
    next_statusWordBits = statusWordBits;
    if (wrSwb)
    begin
      next_statusWordBits = hostWdata;
    end
    if (wdTimeout && watchdogTimeoutFlagEnable)
    begin
      next_statusWordBits[`SIF_SWB_FLAG_BIT] = 1'b1;
    end
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      statusWordBits <= `SIF_SWB_RESET;
    end
    else
    begin
      statusWordBits <= next_statusWordBits;
    end
  end

  assign mcr2Value = {storeMode, 2'b00, flagTestEnable,
    watchdogTimeoutFlagEnable, 3'b000};

  // read data holds between reads; unmapped addresses and the start-only
  // first configuration register read as zero
  always @*
  begin
    next_hostRdata = hostRdata;
    if (hostRead)
    begin
      case (hostAddr)
        `SIF_MCR2_ADDR:
        begin
          next_hostRdata = {8'h00, mcr2Value};
        end
        `SIF_SWB_ADDR:
        begin
          next_hostRdata = statusWordBits;
        end
        default:
        begin
          next_hostRdata = 16'h0000;
        end
      endcase
    end
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      hostRdata <= 16'h0000;
      hostRvalid <= 1'b0;
    end
    else
    begin
      hostRdata <= next_hostRdata;
      hostRvalid <= hostRead;
    end
  end

  // command qualifiers are decoded here and registered below, so the
  // protocol engine sees the forced bits one cycle after the command
  always @*
  begin
    next_forceBusy = 1'b0;
    next_forceFlag = 1'b0;
    if (cmdValid)
    begin
      next_forceBusy = storeMode && cmdOwnAddr;
      next_forceFlag = flagTestEnable && !cmdBroadcast;
    end
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      forceBusy <= 1'b0;
      forceFlag <= 1'b0;
    end
    else
    begin
      forceBusy <= next_forceBusy;
      forceFlag <= next_forceFlag;
    end
  end

  // store mode silences data, interrupts and logging as one group
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      suppressData <= 1'b0;
      suppressIrq <= 1'b0;
      suppressLog <= 1'b0;
      storeModeActive <= 1'b0;
    end
    else
    begin
      suppressData <= storeMode;
      suppressIrq <= storeMode;
      suppressLog <= storeMode;
      storeModeActive <= storeMode;
    end
  end

  // watchdog stop and status flag copies
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      txStop <= 1'b0;
      terminalFlagBit <= 1'b0;
    end
    else
    begin
      txStop <= wdStop;
      terminalFlagBit <= statusWordBits[`SIF_SWB_FLAG_BIT];
    end
  end

  sif_tx_watchdog #(
    .LIMIT(WDOG_CYCLES)
  ) uWatchdog (
    .clk(clk),
    .rst_n(rst_n),
    .txActive(txActive),
    .txStop(wdStop),
    .timeoutPulse(wdTimeout)
  );
endmodule // sif_cfg_bank
`default_nettype wire

// ### dv/sif_bc_model.sv
`timescale 1ns/1ns
`default_nettype none
module sif_bc_model (
  // clock
  input wire logic clk,
  // bench request: valid, own address, broadcast, transmit
  input wire logic [3:0] req,
  // lines to the terminal
  output logic cmdValid,
  output logic cmdOwnAddr,
  output logic cmdBroadcast,
  output logic txActive
);
  always @(posedge clk)
  begin
    cmdValid <= req[3];
    // address match is meaningless without a command, so it wanders
    cmdOwnAddr <= req[3] ? req[2] : ~cmdOwnAddr;
    cmdBroadcast <= req[1];
    txActive <= req[0];
  end
endmodule // sif_bc_model
`default_nettype wire

// ### dv/sif_cfg_bank_chk.sv
`timescale 1ns/1ns
`default_nettype none
module sif_cfg_bank_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmdValid,
  input wire logic cmdOwnAddr,
  input wire logic cmdBroadcast,
  input wire logic txActive,
  input wire logic forceBusy,
  input wire logic forceFlag,
  input wire logic suppressData,
  input wire logic txStop,
  input wire logic storeModeActive
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_on; storeModeActive ##1 storeModeActive; endsequence
  sequence s_off; !storeModeActive ##1 !storeModeActive; endsequence
  property p_busy; cmdValid && cmdOwnAddr ##0 s_on |-> forceBusy; endproperty
  property p_idle; s_off |-> !forceBusy; endproperty
  property p_sup; s_on |-> suppressData; endproperty
  property p_res; s_off |-> !suppressData; endproperty
  property p_own; !cmdOwnAddr |=> !forceBusy; endproperty
  property p_bc; cmdBroadcast |=> !forceFlag; endproperty
  property p_nov; !cmdValid |=> !forceFlag; endproperty
  property p_tx; !txActive [*3] |-> !txStop; endproperty
  a_busy: assert property (p_busy) else $error("no busy");
  a_idle: assert property (p_idle) else $error("busy");
  a_sup: assert property (p_sup) else $error("no hold");
  a_res: assert property (p_res) else $error("hold");
  a_own: assert property (p_own) else $error("busy");
  a_bc: assert property (p_bc) else $error("flag");
  a_nov: assert property (p_nov) else $error("flag");
  a_tx: assert property (p_tx) else $error("stop");
endmodule // sif_cfg_bank_chk
bind sif_cfg_bank sif_cfg_bank_chk i_chk (.clk(clk), .rst_n(rst_n),
  .cmdValid(cmdValid), .cmdOwnAddr(cmdOwnAddr), .cmdBroadcast(cmdBroadcast),
  .txActive(txActive), .forceBusy(forceBusy), .forceFlag(forceFlag),
  .suppressData(suppressData), .txStop(txStop),
  .storeModeActive(storeModeActive));
`default_nettype wire

// ### dv/test_rt_store_mode_and_flag_config.sv
`timescale 1ns/1ns
`default_nettype none
module test_rt_store_mode_and_flag_config;
  logic clk = 0, rst_n = 0, mrPin = 0, modePin = 0, wrS = 0, rdS = 0;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata;
  logic [3:0] req = 4'h0;
  logic cV, cO, cB, tx, busy, flag, sD, sI, sL, stop, rv, sma, tfb;
  int fails = 0, checks_done = 0;
  always #2 clk = ~clk;
  sif_bc_model i_sif_bc_model (.clk(clk), .req(req), .cmdValid(cV),
    .cmdOwnAddr(cO), .cmdBroadcast(cB), .txActive(tx));
  sif_cfg_bank #(.WDOG_CYCLES(20)) i_sif_cfg_bank (.clk(clk), .rst_n(rst_n),
    .masterResetPin(mrPin), .storeInterfaceModePin(modePin), .hostAddr(addr),
    .hostWrite(wrS), .hostRead(rdS), .hostWdata(wdata), .hostRdata(rdata),
    .hostRvalid(rv), .cmdValid(cV), .cmdOwnAddr(cO), .cmdBroadcast(cB),
    .txActive(tx), .forceBusy(busy), .forceFlag(flag), .suppressData(sD),
    .suppressIrq(sI), .suppressLog(sL), .txStop(stop),
    .storeModeActive(sma), .terminalFlagBit(tfb));
  task chk(input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task hostWr(input logic [15:0] a, d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wrS = 1;
    @(negedge clk);
    wrS = 0;
  endtask
  task hostRd(input logic [15:0] a, e);
    @(negedge clk);
    addr = a;
    rdS = 1;
    @(negedge clk);
    rdS = 0;
    chk(rdata, e);
    chk({15'h0000, rv}, 16'h0001);
  endtask
  task cmd(input logic [3:0] r, input logic [1:0] e);
    @(negedge clk);
    req = r;
    repeat (2) @(negedge clk);
    req = 4'h0;
    chk({14'h0000, busy, flag}, {14'h0000, e});
  endtask
  task t_regs;
    hostRd(16'h004E, 16'h0000);
    hostWr(16'h004E, 16'hFFFF);
    hostRd(16'h004E, 16'h0018);
    hostRd(16'h0002, 16'h0000);
  endtask
  task t_modes;
    for (int k = 0; k < 3; k++)
    begin
      modePin = 1;
      mrPin = 0;
      repeat (4) @(negedge clk);
      mrPin = 1;
      repeat (6) @(negedge clk);
      hostRd(16'h004E, 16'h0098);
      chk({15'h0000, sma}, 16'h0001);
      cmd(4'hC, 2'b11);
      chk({13'h0000, sD, sI, sL}, 16'h0007);
      if (k == 0) hostWr(16'h004E, 16'h0098);
      if (k == 1) hostWr(16'h0000, 16'h0010);
      if (k == 2) modePin = 0;
      repeat (4) @(negedge clk);
      hostRd(16'h004E, 16'h0018);
      chk({15'h0000, sma}, 16'h0000);
      cmd(4'hC, 2'b01);
    end
    mrPin = 0;
    repeat (4) @(negedge clk);
    mrPin = 1;
    repeat (6) @(negedge clk);
    hostRd(16'h004E, 16'h0018);
  endtask
  task t_flag;
    cmd(4'hE, 2'b00);
    cmd(4'h8, 2'b01);
    hostWr(16'h004E, 16'h0000);
    cmd(4'h8, 2'b00);
  endtask
  task t_wdog;
    hostWr(16'h004E, 16'h0008);
    req = 4'h1;
    repeat (10) @(negedge clk);
    chk({15'h0000, stop}, 16'h0000);
    repeat (18) @(negedge clk);
    chk({15'h0000, stop}, 16'h0001);
    req = 4'h0;
    repeat (4) @(negedge clk);
    chk({15'h0000, stop}, 16'h0000);
    hostRd(16'h001A, 16'h0001);
    chk({15'h0000, tfb}, 16'h0001);
    hostWr(16'h001A, 16'h0000);
    repeat (2) @(negedge clk);
    chk({15'h0000, tfb}, 16'h0000);
    hostWr(16'h004E, 16'h0000);
    req = 4'h1;
    repeat (28) @(negedge clk);
    req = 4'h0;
    repeat (4) @(negedge clk);
    hostRd(16'h001A, 16'h0000);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #20000;
    fails++;
    wrap_up;
  end
  initial
  begin
    repeat (20) @(negedge clk);
    rst_n = 1;
    t_regs;
    t_modes;
    t_flag;
    t_wdog;
    wrap_up;
  end
endmodule // test_rt_store_mode_and_flag_config
`default_nettype wire
